// ===== hw/amp_protection_defs.vh
`ifndef AMP_PROTECTION_DEFS_VH
`define AMP_PROTECTION_DEFS_VH

// register byte offsets on the apb bus
`define AP_ADDR_CTRL_ONE     8'h00
`define AP_ADDR_CTRL_TWO     8'h04
`define AP_ADDR_STAT_ONE     8'h10
`define AP_ADDR_STAT_TWO     8'h14
`define AP_ADDR_STAT_THREE   8'h18
`define AP_ADDR_STAT_FOUR    8'h1C
`define AP_ADDR_GLOBAL_STAT  8'h20

// control_byte_one fields
`define AP_C1_AMP_ON         0
`define AP_C1_MUTE           1

// control_byte_two fields
`define AP_C2_CH_OFF_LSB     0
`define AP_C2_LOAD_FAULT_INDICATOR_PIN_OFF  4
`define AP_C2_HIGH_LOW_VP    5

// per-channel status byte fields
`define AP_ST_SHORT_GND      0
`define AP_ST_SHORT_VP       1
`define AP_ST_SHORT_LOAD     2
`define AP_ST_SPK_FAULT      6
`define AP_ST_POR_FLAG       7

// global status fields
`define AP_GS_STATE_LSB      0
`define AP_GS_LOW_VP         4
`define AP_GS_LEGACY         5
`define AP_GS_POR_FLAG       7

// reset values
`define AP_CTRL_ONE_RST      2'h0
`define AP_CTRL_TWO_RST      6'h00

// timing, as printed, and clock rate
`define AP_MCLK_KHZ          40000
`define AP_FAST_MUTE_US      400
`define AP_SOFT_MUTE_US      20000
`define AP_RETRY_MS          15

`endif

// ===== hw/amp_protection_sequencer.v
// Behaviour
// - speaker fault during start-up acts as short to ground; channel off.
// - speaker fault while running sets bit D6 only; no switch-off, no fault pin.
// - clearing amplifier-on bit: soft mute first, then ripple-filter discharge.
// - standby pin low gives fast mute then discharge, in both modes.
// - supply below low threshold fast-mutes outputs for about 400 us.
// - ac-ground and ripple-filter capacitors discharge only after the mute ends.
// - after low-supply mute, restart by itself when supply recovers and no reset.
// - any restart waits for ripple-filter capacitor to be discharged.
// - after a serial power-on reset, no automatic restart; wait for start command.
// - legacy mode restarts after a supply dip while standby pin stays high.
// - low threshold defaults low, fixed in legacy; high setting restarts above 8 V.
// - serial power-on reset clears latches, stops amp, sets flag, pulls fault pin.
// - host setting amplifier-on clears flag, releases fault pin, starts up.
// - legacy low supply stops amp; restarts on recovery if standby still enabled.
// - shorts switch off only that channel; channel and kind readable.
// - load short pulls fault pin only when load-fault reporting bit is zero.
// - channel with short to ground or supply stays off while fault persists.
// - load-shorted channel retried after 15 ms; off again if still shorted.
// - several load-shorted channels are retried one at a time.
// - host may disable a shorted channel over the bus.
//
// Our own choices: the register addresses and register access over APB.
`include "amp_protection_defs.vh"

module amp_protection_sequencer #(
  parameter [19:0] FAST_MUTE_CYCLES = `AP_FAST_MUTE_US * `AP_MCLK_KHZ / 1000,
  parameter [19:0] SOFT_MUTE_CYCLES = `AP_SOFT_MUTE_US * `AP_MCLK_KHZ / 1000,
  parameter [19:0] RETRY_CYCLES     = `AP_RETRY_MS * `AP_MCLK_KHZ
) (
  input  wire        MCLK,
  input  wire        SYS_RST,
  input  wire        PSEL,
  input  wire        PENABLE,
  input  wire        PWRITE,
  input  wire [7:0]  PADDR,
  input  wire [31:0] PWDATA,
  output reg  [31:0] PRDATA,
  output wire        PREADY,
  output wire        PSLVERR,
  input  wire        LEGACY_MODE,
  input  wire        STANDBY_MUTE_PIN_ON,
  input  wire        STANDBY_MUTE_PIN_UNMUTE,
  input  wire        VP_ABOVE_LOW,
  input  wire        VP_ABOVE_HIGH,
  input  wire        VP_ABOVE_RESTART_HIGH,
  input  wire        VP_POR,
  input  wire        STARTUP_DONE,
  input  wire        RIPPLE_FILTER_CAP_LOW,
  input  wire [3:0]  SHORT_GND,
  input  wire [3:0]  SHORT_VP,
  input  wire [3:0]  SHORT_LOAD,
  input  wire [3:0]  SPEAKER_FAULT,
  output wire [3:0]  CH_ENABLE,
  output reg         AMP_ON,
  output reg         SOFT_MUTE,
  output reg         FAST_MUTE,
  output reg         RIPPLE_FILTER_CAP_DISCHARGE,
  output reg         AC_GROUND_CAP_DISCHARGE,
  output wire        HIGH_LOW_VP_SELECT,
  output wire        FAULT_INDICATOR_PIN_O,
  output reg         FAULT_INDICATOR_PIN_OE
);

  localparam [2:0] ST_OFF   = 3'h0;
  localparam [2:0] ST_START = 3'h1;
  localparam [2:0] ST_RUN   = 3'h2;
  localparam [2:0] ST_MUTE  = 3'h3;
  localparam [2:0] ST_DISCH = 3'h4;

  // one-hot channel select for the four status byte offsets
  function [3:0] ch_sel;
    input [7:0] addr;
    begin
      case (addr)
        `AP_ADDR_STAT_ONE:   ch_sel = 4'h1;
        `AP_ADDR_STAT_TWO:   ch_sel = 4'h2;
        `AP_ADDR_STAT_THREE: ch_sel = 4'h4;
        `AP_ADDR_STAT_FOUR:  ch_sel = 4'h8;
        default:             ch_sel = 4'h0;
      endcase
    end
  endfunction

  // two-stage synchroniser on every comparator and pin input
  wire [24:0] raw_in = {SPEAKER_FAULT, SHORT_LOAD, SHORT_VP, SHORT_GND,
                        STANDBY_MUTE_PIN_UNMUTE, STANDBY_MUTE_PIN_ON, RIPPLE_FILTER_CAP_LOW,
                        STARTUP_DONE, VP_POR, VP_ABOVE_RESTART_HIGH, VP_ABOVE_HIGH,
                        VP_ABOVE_LOW, LEGACY_MODE};
  reg  [24:0] meta_reg;
  reg  [24:0] sync_reg;

  always @(posedge MCLK) begin
    if (SYS_RST) begin
      meta_reg <= 25'h000_0000;
      sync_reg <= 25'h000_0000;
    end else begin
      meta_reg <= raw_in;
      sync_reg <= meta_reg;
    end
  end

  wire       legacy      = sync_reg[0];
  wire       vp_low_ok   = sync_reg[1];
  wire       vp_high_ok  = sync_reg[2];
  wire       vp_8v_ok    = sync_reg[3];
  wire       por_det     = sync_reg[4];
  wire       started     = sync_reg[5];
  wire       cap_low     = sync_reg[6];
  wire       stb_on      = sync_reg[7];
  wire       stb_unmute  = sync_reg[8];
  wire [3:0] sh_gnd      = sync_reg[12:9];
  wire [3:0] sh_vp       = sync_reg[16:13];
  wire [3:0] sh_load     = sync_reg[20:17];
  wire [3:0] spk         = sync_reg[24:21];

  reg  [1:0]  ctrl_one_reg;
  reg  [5:0]  ctrl_two_reg;
  reg         por_flag_reg;
  reg  [2:0]  state_reg;
  reg  [2:0]  state_next;
  reg  [19:0] mute_cnt_reg;
  reg         fast_reg;
  reg         lvp_cause_reg;
  reg  [3:0]  flag_gnd_reg;
  reg  [3:0]  flag_vp_reg;
  reg  [3:0]  flag_load_reg;
  reg  [3:0]  flag_spk_reg;
  reg  [3:0]  blocked_reg;
  reg  [3:0]  load_off_reg;
  reg  [19:0] retry_cnt_reg;
  reg  [1:0]  rr_reg;
  reg  [3:0]  grant;
  reg  [1:0]  grant_idx;
  reg         found;
  reg  [1:0]  idx;
  reg  [31:0] rd_mux;
  integer     k;
  integer     j;

  wire wr_access = PSEL & PENABLE & PWRITE;
  wire rd_setup  = PSEL & ~PENABLE & ~PWRITE;
  wire [3:0] st_sel = ch_sel(PADDR);
  wire mapped = (PADDR == `AP_ADDR_CTRL_ONE) | (PADDR == `AP_ADDR_CTRL_TWO) |
                (PADDR == `AP_ADDR_GLOBAL_STAT) | (|st_sel);

  assign PREADY  = 1'b1;
  assign PSLVERR = PSEL & PENABLE & ~mapped;

  // legacy mode has no bus, so the threshold stays at the lower setting
  assign HIGH_LOW_VP_SELECT = ~legacy & ctrl_two_reg[`AP_C2_HIGH_LOW_VP];
  wire low_vp     = HIGH_LOW_VP_SELECT ? ~vp_high_ok : ~vp_low_ok;
  wire restart_ok = HIGH_LOW_VP_SELECT ? vp_8v_ok : vp_low_ok;
  // a dropped standby pin removes the request in either mode
  wire amp_req    = stb_on & (legacy | (ctrl_one_reg[`AP_C1_AMP_ON] & ~por_flag_reg));
  wire running    = (state_reg == ST_START) | (state_reg == ST_RUN);
  wire por_serial = por_det & ~legacy;
  wire on_write   = wr_access & (PADDR == `AP_ADDR_CTRL_ONE) & PWDATA[`AP_C1_AMP_ON];

  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_OFF: begin
        // restart only from a discharged ripple filter, and outside legacy mode never while flagged
        if (amp_req & ~low_vp & restart_ok & cap_low)
          state_next = ST_START;
      end
      ST_START: begin
        if (low_vp | ~amp_req)
          state_next = ST_MUTE;
        else if (started)
          state_next = ST_RUN;
      end
      ST_RUN: begin
        if (low_vp | ~amp_req)
          state_next = ST_MUTE;
      end
      ST_MUTE: begin
        if (mute_cnt_reg == 20'h0_0000)
          state_next = ST_DISCH;
      end
      ST_DISCH: begin
        if (cap_low)
          state_next = ST_OFF;
      end
      default: state_next = ST_OFF;
    endcase
  end

  always @(posedge MCLK) begin
    if (SYS_RST) begin
      state_reg     <= ST_OFF;
      mute_cnt_reg  <= 20'h0_0000;
      fast_reg      <= 1'b0;
      lvp_cause_reg <= 1'b0;
    end else if (por_det) begin
      state_reg     <= ST_OFF;
      mute_cnt_reg  <= 20'h0_0000;
      fast_reg      <= 1'b0;
      lvp_cause_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      if (running & (state_next == ST_MUTE)) begin
        // supply dip or dropped standby pin takes the short fast mute
        fast_reg      <= low_vp | ~stb_on;
        lvp_cause_reg <= low_vp;
        mute_cnt_reg  <= (low_vp | ~stb_on) ? FAST_MUTE_CYCLES - 20'h0_0001
                                            : SOFT_MUTE_CYCLES - 20'h0_0001;
      end else if ((state_reg == ST_MUTE) & (mute_cnt_reg != 20'h0_0000)) begin
        mute_cnt_reg <= mute_cnt_reg - 20'h0_0001;
      end
      if (state_next == ST_START)
        lvp_cause_reg <= 1'b0;
    end
  end

  // control latches; a serial power-on reset wipes them
  always @(posedge MCLK) begin
    if (SYS_RST) begin
      ctrl_one_reg <= `AP_CTRL_ONE_RST;
      ctrl_two_reg <= `AP_CTRL_TWO_RST;
      por_flag_reg <= 1'b0;
    end else if (por_serial) begin
      ctrl_one_reg <= `AP_CTRL_ONE_RST;
      ctrl_two_reg <= `AP_CTRL_TWO_RST;
      por_flag_reg <= 1'b1;
    end else begin
      if (wr_access & (PADDR == `AP_ADDR_CTRL_ONE))
        ctrl_one_reg <= PWDATA[1:0];
      if (wr_access & (PADDR == `AP_ADDR_CTRL_TWO))
        ctrl_two_reg <= PWDATA[5:0];
      if (on_write)
        por_flag_reg <= 1'b0;
    end
  end

  // load-short retry: one shared timer, round robin over pending channels
  always @* begin
    grant     = 4'h0;
    grant_idx = rr_reg;
    found     = 1'b0;
    idx       = 2'h0;
    for (k = 0; k < 4; k = k + 1) begin
      idx = rr_reg + k[1:0];
      if (~found & load_off_reg[idx] & (retry_cnt_reg == RETRY_CYCLES - 20'h0_0001)) begin
        grant[idx] = 1'b1;
        grant_idx  = idx;
        found      = 1'b1;
      end
    end
  end

  always @(posedge MCLK) begin
    if (SYS_RST) begin
      retry_cnt_reg <= 20'h0_0000;
      rr_reg        <= 2'h0;
    end else if (~(|load_off_reg)) begin
      retry_cnt_reg <= 20'h0_0000;
    end else if (found) begin
      // timer restarts per grant so retries never overlap
      retry_cnt_reg <= 20'h0_0000;
      rr_reg        <= grant_idx + 2'h1;
    end else begin
      retry_cnt_reg <= retry_cnt_reg + 20'h0_0001;
    end
  end

  genvar i;
  generate
    for (i = 0; i < 4; i = i + 1) begin : chan
      wire clr     = wr_access & st_sel[i];
      // start-up cannot tell a speaker fault from a short to ground
      wire gnd_hit = sh_gnd[i] | ((state_reg == ST_START) & spk[i]);
      wire hard    = gnd_hit | sh_vp[i];

      assign CH_ENABLE[i] = running & ~blocked_reg[i] & ~load_off_reg[i] &
                            ~ctrl_two_reg[`AP_C2_CH_OFF_LSB + i];

      always @(posedge MCLK) begin
        if (SYS_RST) begin
          blocked_reg[i]   <= 1'b0;
          load_off_reg[i]  <= 1'b0;
          flag_gnd_reg[i]  <= 1'b0;
          flag_vp_reg[i]   <= 1'b0;
          flag_load_reg[i] <= 1'b0;
          flag_spk_reg[i]  <= 1'b0;
        end else begin
          if (CH_ENABLE[i] & hard)
            blocked_reg[i] <= 1'b1;
          // a speaker fault caught at start-up keeps the channel off while it persists
          else if (~hard & ~spk[i])
            blocked_reg[i] <= 1'b0;
          if (~running)
            load_off_reg[i] <= 1'b0;
          else if (CH_ENABLE[i] & sh_load[i])
            load_off_reg[i] <= 1'b1;
          else if (grant[i])
            load_off_reg[i] <= 1'b0;
          // a new event outranks a clear written in the same cycle
          flag_gnd_reg[i]  <= (flag_gnd_reg[i] & ~(clr & PWDATA[`AP_ST_SHORT_GND])) |
                              (CH_ENABLE[i] & gnd_hit);
          flag_vp_reg[i]   <= (flag_vp_reg[i] & ~(clr & PWDATA[`AP_ST_SHORT_VP])) |
                              (CH_ENABLE[i] & sh_vp[i]);
          flag_load_reg[i] <= (flag_load_reg[i] & ~(clr & PWDATA[`AP_ST_SHORT_LOAD])) |
                              (CH_ENABLE[i] & sh_load[i]);
          flag_spk_reg[i]  <= (flag_spk_reg[i] & ~(clr & PWDATA[`AP_ST_SPK_FAULT])) |
                              ((state_reg == ST_RUN) & CH_ENABLE[i] & spk[i]);
        end
      end
    end
  endgenerate

  // fault pin is open drain; speaker faults in ST_RUN never reach it
  wire short_rpt = ~legacy & ctrl_two_reg[`AP_C2_LOAD_FAULT_INDICATOR_PIN_OFF];
  // the report-off bit hides every kind of short from the pin, not only load shorts
  wire pull_low  = (~legacy & por_flag_reg) | low_vp |
                   (((|blocked_reg) | (|load_off_reg)) & ~short_rpt);
  wire user_mute = legacy ? (stb_on & ~stb_unmute) : ctrl_one_reg[`AP_C1_MUTE];

  assign FAULT_INDICATOR_PIN_O = 1'b0;

  always @(posedge MCLK) begin
    if (SYS_RST) begin
      FAULT_INDICATOR_PIN_OE      <= 1'b0;
      AMP_ON                      <= 1'b0;
      SOFT_MUTE                   <= 1'b0;
      FAST_MUTE                   <= 1'b0;
      RIPPLE_FILTER_CAP_DISCHARGE <= 1'b0;
      AC_GROUND_CAP_DISCHARGE     <= 1'b0;
    end else begin
      FAULT_INDICATOR_PIN_OE      <= pull_low;
      AMP_ON                      <= running;
      SOFT_MUTE                   <= ((state_reg == ST_MUTE) & ~fast_reg) | (running & user_mute);
      FAST_MUTE                   <= (state_reg == ST_MUTE) & fast_reg;
      RIPPLE_FILTER_CAP_DISCHARGE <= (state_reg == ST_DISCH) | (state_reg == ST_OFF);
      AC_GROUND_CAP_DISCHARGE     <= ((state_reg == ST_DISCH) | (state_reg == ST_OFF)) &
                                     lvp_cause_reg;
    end
  end

  always @* begin
    rd_mux = 32'h0000_0000;
    case (PADDR)
      `AP_ADDR_CTRL_ONE:    rd_mux[1:0] = ctrl_one_reg;
      `AP_ADDR_CTRL_TWO:    rd_mux[5:0] = ctrl_two_reg;
      `AP_ADDR_GLOBAL_STAT: begin
        rd_mux[`AP_GS_STATE_LSB + 2:`AP_GS_STATE_LSB] = state_reg;
        rd_mux[`AP_GS_LOW_VP]   = low_vp;
        rd_mux[`AP_GS_LEGACY]   = legacy;
        rd_mux[`AP_GS_POR_FLAG] = por_flag_reg;
      end
      default: begin
        for (j = 0; j < 4; j = j + 1) begin
          if (st_sel[j]) begin
            rd_mux[`AP_ST_SHORT_GND]  = flag_gnd_reg[j];
            rd_mux[`AP_ST_SHORT_VP]   = flag_vp_reg[j];
            rd_mux[`AP_ST_SHORT_LOAD] = flag_load_reg[j];
            rd_mux[`AP_ST_SPK_FAULT]  = flag_spk_reg[j];
          end
        end
        if (st_sel[1])
          rd_mux[`AP_ST_POR_FLAG] = por_flag_reg;
      end
    endcase
  end

  // read data captured in the setup phase so it is a flop in the access phase
  always @(posedge MCLK) begin
    if (SYS_RST)
      PRDATA <= 32'h0000_0000;
    else if (rd_setup)
      PRDATA <= rd_mux;
  end

endmodule

// ===== test/amp_host_model.sv
module amp_host_model (
  input  wire  mclk,
  input  wire  amp_on,
  input  wire  cap_discharge,
  input  wire  fault_o,
  input  wire  fault_oe,
  output logic startup_done,
  output logic cap_low,
  output wire  fault_level
);
  timeunit 1ns;
  timeprecision 1ps;
  int up_cnt  = 0;
  int dis_cnt = 0;
  initial startup_done = 1'b0;
  initial cap_low = 1'b1;
  // open-drain fault line with pull-up: released reads high
  assign fault_level = fault_oe ? fault_o : 1'b1;
  always @(posedge mclk) begin
    up_cnt <= amp_on ? up_cnt + 1 : 0;
    startup_done <= amp_on && (up_cnt >= 10);
    dis_cnt <= cap_discharge ? dis_cnt + 1 : 0;
    // cap charges while running, settles low only after a real discharge
    if (amp_on)
      cap_low <= 1'b0;
    else if (dis_cnt >= 8)
      cap_low <= 1'b1;
  end
endmodule

// ===== test/amp_protection_chk.sv
module amp_protection_chk (
  input wire       MCLK,
  input wire       SYS_RST,
  input wire       LEGACY_MODE,
  input wire       STANDBY_MUTE_PIN_ON,
  input wire       VP_ABOVE_LOW,
  input wire       VP_POR,
  input wire       STARTUP_DONE,
  input wire       RIPPLE_FILTER_CAP_LOW,
  input wire [3:0] SPEAKER_FAULT,
  input wire [3:0] SHORT_GND,
  input wire [3:0] CH_ENABLE,
  input wire       AMP_ON,
  input wire       SOFT_MUTE,
  input wire       FAST_MUTE,
  input wire       RIPPLE_FILTER_CAP_DISCHARGE,
  input wire       AC_GROUND_CAP_DISCHARGE,
  input wire       FAULT_INDICATOR_PIN_OE
);
  default clocking @(posedge MCLK); endclocking
  default disable iff (SYS_RST);
  property p_fast_len;
    $rose(FAST_MUTE) |-> FAST_MUTE[*8] ##1 FAST_MUTE[*8] ##1 FAST_MUTE[*4] ##[1:2] !FAST_MUTE;
  endproperty
  a_fast_len: assert property (p_fast_len) else $error("fast mute length wrong");
  property p_mute_dis;
    $fell(SOFT_MUTE || FAST_MUTE) |-> ##[0:2] RIPPLE_FILTER_CAP_DISCHARGE;
  endproperty
  a_mute_dis: assert property (p_mute_dis) else $error("no discharge after mute");
  property p_soft_nodis;
    SOFT_MUTE |-> !RIPPLE_FILTER_CAP_DISCHARGE;
  endproperty
  a_soft_nodis: assert property (p_soft_nodis) else $error("discharge during soft mute");
  property p_ac_after;
    AC_GROUND_CAP_DISCHARGE |-> !FAST_MUTE && !SOFT_MUTE;
  endproperty
  a_ac_after: assert property (p_ac_after) else $error("ac ground discharge before mute end");
  property p_restart_cap;
    $rose(AMP_ON) |-> $past(RIPPLE_FILTER_CAP_LOW, 3);
  endproperty
  a_restart_cap: assert property (p_restart_cap) else $error("restart with charged cap");
  property p_lowvp;
    AMP_ON && $fell(VP_ABOVE_LOW) |-> ##[2:5] (FAST_MUTE || !AMP_ON);
  endproperty
  a_lowvp: assert property (p_lowvp) else $error("no mute on low supply");
  property p_stb;
    !LEGACY_MODE && AMP_ON && $fell(STANDBY_MUTE_PIN_ON) |-> ##[2:5] FAST_MUTE;
  endproperty
  a_stb: assert property (p_stb) else $error("no fast mute on standby low");
  property p_spk_run;
    $rose(SPEAKER_FAULT[1]) && STARTUP_DONE && $past(STARTUP_DONE, 8) && CH_ENABLE[1]
      |-> (CH_ENABLE[1] && !FAULT_INDICATOR_PIN_OE)[*6];
  endproperty
  a_spk_run: assert property (p_spk_run) else $error("speaker fault stopped channel");
  property p_gnd_off;
    SHORT_GND[0][*6] |-> !CH_ENABLE[0];
  endproperty
  a_gnd_off: assert property (p_gnd_off) else $error("shorted channel enabled");
  property p_por;
    (VP_POR && !LEGACY_MODE)[*6] |-> FAULT_INDICATOR_PIN_OE && !AMP_ON;
  endproperty
  a_por: assert property (p_por) else $error("reset not flagged");
  c_soft: cover property ($fell(SOFT_MUTE));
  c_acg: cover property ($rose(AC_GROUND_CAP_DISCHARGE));
  c_por: cover property ($fell(VP_POR));
endmodule
bind amp_protection_sequencer amp_protection_chk chk (
  .MCLK(MCLK), .SYS_RST(SYS_RST), .LEGACY_MODE(LEGACY_MODE), .STANDBY_MUTE_PIN_ON(STANDBY_MUTE_PIN_ON),
  .VP_ABOVE_LOW(VP_ABOVE_LOW), .VP_POR(VP_POR), .STARTUP_DONE(STARTUP_DONE),
  .RIPPLE_FILTER_CAP_LOW(RIPPLE_FILTER_CAP_LOW), .SPEAKER_FAULT(SPEAKER_FAULT), .SHORT_GND(SHORT_GND),
  .CH_ENABLE(CH_ENABLE), .AMP_ON(AMP_ON), .SOFT_MUTE(SOFT_MUTE), .FAST_MUTE(FAST_MUTE),
  .RIPPLE_FILTER_CAP_DISCHARGE(RIPPLE_FILTER_CAP_DISCHARGE),
  .AC_GROUND_CAP_DISCHARGE(AC_GROUND_CAP_DISCHARGE), .FAULT_INDICATOR_PIN_OE(FAULT_INDICATOR_PIN_OE));

// ===== test/amp_protection_sequencer_bench.sv
`include "amp_protection_defs.vh"
module amp_protection_sequencer_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        mclk = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic        legacy = 0, stb_on = 1, stb_unmute = 1, vp_low = 1, vp_high = 1, vp_rst8 = 1, vp_por = 0;
  logic [3:0]  sh_gnd = 4'h0, sh_vp = 4'h0, sh_load = 4'h0, spk = 4'h0;
  wire  [31:0] prdata;
  wire  [3:0]  ch_en;
  wire         pready, pslverr, st_done, cap_low, amp_on, soft_mute, fast_mute, cap_dis, acg_dis;
  wire         hl_sel, fault_indicator_pin_o, fault_indicator_pin_oe, fault_indicator_pin_lvl;
  wire  [3:0]  obs = {acg_dis, fast_mute, soft_mute, amp_on};
  int          fails = 0, n_checks = 0, n;
  int          hi[3];
  logic [32:0] rq[$];
  always #12.5 mclk = ~mclk;
  amp_protection_sequencer #(.FAST_MUTE_CYCLES(20'h0_0014), .SOFT_MUTE_CYCLES(20'h0_0028),
    .RETRY_CYCLES(20'h0_0032)) dut (
    .MCLK(mclk), .SYS_RST(sys_rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
    .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .LEGACY_MODE(legacy),
    .STANDBY_MUTE_PIN_ON(stb_on), .STANDBY_MUTE_PIN_UNMUTE(stb_unmute), .VP_ABOVE_LOW(vp_low),
    .VP_ABOVE_HIGH(vp_high), .VP_ABOVE_RESTART_HIGH(vp_rst8), .VP_POR(vp_por), .STARTUP_DONE(st_done),
    .RIPPLE_FILTER_CAP_LOW(cap_low), .SHORT_GND(sh_gnd), .SHORT_VP(sh_vp), .SHORT_LOAD(sh_load),
    .SPEAKER_FAULT(spk), .CH_ENABLE(ch_en), .AMP_ON(amp_on), .SOFT_MUTE(soft_mute), .FAST_MUTE(fast_mute),
    .RIPPLE_FILTER_CAP_DISCHARGE(cap_dis), .AC_GROUND_CAP_DISCHARGE(acg_dis), .HIGH_LOW_VP_SELECT(hl_sel),
    .FAULT_INDICATOR_PIN_O(fault_indicator_pin_o), .FAULT_INDICATOR_PIN_OE(fault_indicator_pin_oe));
  amp_host_model host (.mclk(mclk), .amp_on(amp_on), .cap_discharge(cap_dis), .fault_o(fault_indicator_pin_o),
    .fault_oe(fault_indicator_pin_oe), .startup_done(st_done), .cap_low(cap_low), .fault_level(fault_indicator_pin_lvl));
  task check(input logic [32:0] seen, input logic [32:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task tick(input int k);
    repeat (k) @(posedge mclk);
    #1;
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [32:0] e);
    @(posedge mclk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    if (!w) rq.push_back(e);
    @(posedge mclk);
    penable <= 1;
    @(posedge mclk);
    while (pready !== 1'b1) @(posedge mclk);
    psel <= 0;
    penable <= 0;
  endtask
  // bounded wait on one observed output
  task wait_sig(input int b, input logic v);
    for (int i = 0; i < 3000 && obs[b] !== v; i++) tick(1);
    check(obs[b], v);
  endtask
  task dur(input int b, output int k);
    k = 0;
    while (obs[b] === 1'b1 && k < 5000) begin
      tick(1);
      k++;
    end
  endtask
  task watch(input int cyc);
    hi = '{0, 0, 0};
    repeat (cyc) begin
      tick(1);
      hi[0] += ch_en[2];
      hi[1] += ch_en[3];
      hi[2] += ch_en[2] & ch_en[3];
    end
  endtask
  always @(posedge mclk)
    if (psel && penable && pready && !pwrite) check({pslverr, prdata}, rq.pop_front());
  initial begin
    #1000000;
    fails++;
    $display("Error at %0t: watchdog expired", $time);
    report_and_stop;
  end
  initial begin
    n = $urandom(32'h6557);
    repeat (20) @(posedge mclk);
    sys_rst <= 0;
    apb(0, `AP_ADDR_CTRL_ONE, 0, 0);
    apb(0, `AP_ADDR_GLOBAL_STAT, 0, 0);
    apb(0, 8'h0C, 0, 33'h1_0000_0000);
    n = $urandom & 32'h3F;
    apb(1, `AP_ADDR_CTRL_TWO, n, 0);
    apb(0, `AP_ADDR_CTRL_TWO, 0, n);
    apb(1, `AP_ADDR_CTRL_TWO, 32'h20, 0);
    tick(2);
    check(hl_sel, 1);
    apb(1, `AP_ADDR_CTRL_TWO, 0, 0);
    tick(2);
    check(hl_sel, 0);
    apb(1, `AP_ADDR_CTRL_ONE, 1, 0);
    wait_sig(0, 1);
    tick(30);
    apb(0, `AP_ADDR_GLOBAL_STAT, 0, 2);
    @(posedge mclk) spk <= 4'h2;
    tick(10);
    check({ch_en, fault_indicator_pin_lvl}, 5'h1F);
    apb(0, `AP_ADDR_STAT_TWO, 0, 32'h40);
    @(posedge mclk) spk <= 0;
    apb(1, `AP_ADDR_STAT_TWO, 32'h40, 0);
    for (int k = 0; k < 2; k++) begin
      @(posedge mclk) {sh_vp, sh_gnd} <= k ? 8'h10 : 8'h01;
      tick(60);
      check({ch_en, fault_indicator_pin_lvl}, 5'h1C);
      apb(0, `AP_ADDR_STAT_ONE, 0, 1 << k);
      apb(1, `AP_ADDR_CTRL_TWO, 32'h10, 0);
      tick(3);
      check(fault_indicator_pin_lvl, 1);
      apb(1, `AP_ADDR_CTRL_TWO, 0, 0);
      @(posedge mclk) {sh_vp, sh_gnd} <= 0;
      tick(10);
      check(ch_en, 4'hF);
      apb(1, `AP_ADDR_STAT_ONE, 3, 0);
    end
    @(posedge mclk) sh_load <= 4'hC;
    tick(6);
    watch(300);
    check(hi[2], 0);
    check(hi[0] > 0 && hi[0] < 30 && hi[1] > 0 && hi[1] < 30, 1);
    check(fault_indicator_pin_lvl, 0);
    apb(1, `AP_ADDR_CTRL_TWO, 4, 0);
    watch(200);
    check(hi[0], 0);
    @(posedge mclk) sh_load <= 0;
    apb(1, `AP_ADDR_CTRL_TWO, 0, 0);
    tick(120);
    check(ch_en, 4'hF);
    apb(1, `AP_ADDR_CTRL_ONE, 0, 0);
    wait_sig(1, 1);
    dur(1, n);
    check(n >= 40 && n <= 41, 1);
    apb(1, `AP_ADDR_CTRL_ONE, 1, 0);
    wait_sig(0, 1);
    tick(30);
    @(posedge mclk) stb_on <= 0;
    wait_sig(2, 1);
    dur(2, n);
    check(n >= 20 && n <= 21, 1);
    @(posedge mclk) stb_on <= 1;
    wait_sig(0, 1);
    tick(30);
    @(posedge mclk) {vp_low, vp_high, vp_rst8} <= 3'h0;
    wait_sig(2, 1);
    wait_sig(3, 1);
    check(fast_mute, 0);
    @(posedge mclk) {vp_low, vp_high, vp_rst8} <= 3'h7;
    wait_sig(0, 1);
    // high threshold: dip below it mutes, restart waits for the upper restart level
    apb(1, `AP_ADDR_CTRL_TWO, 32'h20, 0);
    @(posedge mclk) {vp_high, vp_rst8} <= 2'h0;
    wait_sig(2, 1);
    @(posedge mclk) vp_high <= 1;
    tick(100);
    check(amp_on, 0);
    @(posedge mclk) vp_rst8 <= 1;
    wait_sig(0, 1);
    apb(1, `AP_ADDR_CTRL_TWO, 0, 0);
    tick(30);
    @(posedge mclk) vp_por <= 1;
    tick(10);
    @(posedge mclk) vp_por <= 0;
    tick(5);
    check({amp_on, fault_indicator_pin_lvl}, 2'h0);
    apb(0, `AP_ADDR_CTRL_ONE, 0, 0);
    apb(0, `AP_ADDR_STAT_TWO, 0, 32'h80);
    tick(100);
    check(amp_on, 0);
    apb(1, `AP_ADDR_CTRL_ONE, 1, 0);
    tick(4);
    check(fault_indicator_pin_lvl, 1);
    wait_sig(0, 1);
    tick(30);
    @(posedge mclk) legacy <= 1;
    apb(1, `AP_ADDR_CTRL_TWO, 32'h20, 0);
    tick(4);
    check(hl_sel, 0);
    @(posedge mclk) {vp_low, vp_high, vp_rst8} <= 3'h0;
    wait_sig(0, 0);
    @(posedge mclk) spk <= 4'h1;
    tick(20);
    @(posedge mclk) {vp_low, vp_high, vp_rst8} <= 3'h7;
    wait_sig(0, 1);
    tick(30);
    check(ch_en[0], 0);
    apb(0, `AP_ADDR_STAT_ONE, 0, 1);
    // legacy switch-off: mute level held before grounding the pin
    @(posedge mclk) stb_unmute <= 0;
    tick(60);
    @(posedge mclk) stb_on <= 0;
    wait_sig(0, 0);
    report_and_stop;
  end
endmodule
